// ===== hdl/rx_port_interrupt_status.sv
// Notes on behaviour
// RULE1: Port select register picks which receive port the per-port accesses reach.
// RULE2: Line length change sets status bit 6; reading port status two clears it.
// RULE3: Line count change sets status bit 5; reading port status two clears it.
// RULE4: Buffer overflow sets status bit 4; reading port status two clears it.
// RULE5: Link parity error sets status bit 2; reading port status one clears it.
// RULE6: Port valid change sets status bit 1; reading port status one clears it.
// RULE7: Lock change sets status bit 0; reading port status one clears it.
// RULE8: GPIO3..0 flags in bits 7..4 set on enabled edges, cleared on read.
// RULE9: GPIO3..0 present levels read in bits 3..0, no side effect.
// RULE10: Falling edge flagged where fall enable bits 7,5,3,1 are set.
// RULE11: Rising edge flagged where rise enable bits 6,4,2,0 are set.
// RULE12: Masked sensor status rising edges latch in sensor rise status.
// RULE13: Reading sensor rise status clears the latched bits.
// RULE14: Port status bits reach the interrupt only through their enable bits.
// RULE15: Interrupt high while any latched enabled bit of any port is set.
// RULE16: Reserved status bits 7 and 3 read zero and ignore writes.

`default_nettype none

module rx_port_interrupt_status
  import rx_irq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_irq,
  input wire logic [3:0] i_line_len_chg,
  input wire logic [3:0] i_line_cnt_chg,
  input wire logic [3:0] i_buf_overflow,
  input wire logic [3:0] i_parity_err,
  input wire logic [3:0] i_valid_chg,
  input wire logic [3:0] i_lock_chg,
  input wire logic [3:0][3:0] i_fwd_gpio_level,
  input wire logic [3:0][7:0] i_sensor_status_bits,
  input wire logic [3:0][7:0] i_sensor_rise_mask
);
  port_sel_t port_sel_q, port_sel_d;
  logic [3:0][7:0] ctrl_low_q, ctrl_low_d;
  logic [3:0][7:0] gpio_ctrl_q, gpio_ctrl_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d, irq_q, irq_d;
  reg_id_t wsel, rsel;
  logic [3:0] clr_one, clr_two, clr_gpio, clr_sensor;
  logic [3:0][7:0] stat_all, gpio_all, srise_all;
  logic [3:0] pend;
  logic [7:0] sel_stat;

  // ****************************************************************
  // Address decode and per-port clear strobes
  // ****************************************************************
  // Clears go only to the port currently selected
  always_comb begin
    wsel = decode_addr(i_addr);
    rsel = decode_addr(i_addr);
    for (int p = 0; p < 4; p++) begin
      clr_one[p] = i_rd && rsel == REG_PORT_STATUS_ONE
                   && port_sel_q == p[1:0]; // see RULE1
      clr_two[p] = i_rd && rsel == REG_PORT_STATUS_TWO
                   && port_sel_q == p[1:0];
      clr_gpio[p] = i_rd && rsel == REG_GPIO_STATUS
                    && port_sel_q == p[1:0]; // see RULE8
      clr_sensor[p] = i_rd && rsel == REG_SENSOR_RISE
                      && port_sel_q == p[1:0]; // see RULE13
    end
  end

  // ****************************************************************
  // Per-port status units
  // ****************************************************************
  for (genvar g = 0; g < 4; g++) begin : g_port
    port_irq_unit u_unit (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_line_len_chg(i_line_len_chg[g]),
      .i_line_cnt_chg(i_line_cnt_chg[g]),
      .i_buf_overflow(i_buf_overflow[g]),
      .i_parity_err(i_parity_err[g]),
      .i_valid_chg(i_valid_chg[g]),
      .i_lock_chg(i_lock_chg[g]),
      .i_gpio_level(i_fwd_gpio_level[g]),
      .i_gpio_ctrl(gpio_ctrl_q[g]),
      .i_sensor_status_bits(i_sensor_status_bits[g]),
      .i_sensor_rise_mask(i_sensor_rise_mask[g]),
      .i_clr_one(clr_one[g]),
      .i_clr_two(clr_two[g]),
      .i_clr_gpio(clr_gpio[g]),
      .i_clr_sensor(clr_sensor[g]),
      .o_status_low(stat_all[g]),
      .o_gpio_status(gpio_all[g]),
      .o_sensor_rise(srise_all[g])
    );
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Status registers are read only, so writes to them fall through
  always_comb begin
    port_sel_d = port_sel_q;
    ctrl_low_d = ctrl_low_q;
    gpio_ctrl_d = gpio_ctrl_q;
    if (i_wr) begin
      if (wsel == REG_PORT_SELECT) begin
        port_sel_d = i_wdata[1:0]; // see RULE1
      end else if (wsel == REG_CONTROL_LOW) begin
        ctrl_low_d[port_sel_q] = i_wdata & `STATUS_LOW_VALID_MASK;
      end else if (wsel == REG_GPIO_CONTROL) begin
        gpio_ctrl_d[port_sel_q] = i_wdata; // see RULE11
      end
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // Read data is captured before the clear lands on the same edge
  always_comb begin
    sel_stat = stat_all[port_sel_q]; // see RULE1
    rvalid_d = i_rd;
    rdata_d = 8'h00;
    if (i_rd) begin
      case (rsel)
        REG_PORT_SELECT: rdata_d = {6'h00, port_sel_q};
        REG_CONTROL_LOW: rdata_d = ctrl_low_q[port_sel_q];
        REG_STATUS_LOW: rdata_d = sel_stat; // see RULE16
        REG_GPIO_STATUS: rdata_d = gpio_all[port_sel_q]; // see RULE9
        REG_SENSOR_RISE: rdata_d = srise_all[port_sel_q]; // see RULE13
        default: rdata_d = 8'h00; // Write only or not held here
      endcase
    end
  end

  // ****************************************************************
  // Interrupt output
  // ****************************************************************
  // GPIO and sensor flags are already gated when they are latched
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      pend[p] = |(stat_all[p] & ctrl_low_q[p]) // see RULE14
                | (|gpio_all[p][7:4]) | (|srise_all[p]);
    end
    irq_d = |pend; // see RULE15
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      port_sel_q <= `PORT_SELECT_RESET;
      ctrl_low_q <= '0;
      gpio_ctrl_q <= '0;
      rdata_q <= `REG_RESET_VALUE;
      rvalid_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      port_sel_q <= port_sel_d;
      ctrl_low_q <= ctrl_low_d;
      gpio_ctrl_q <= gpio_ctrl_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      irq_q <= irq_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_irq = irq_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_sel_read;
    (i_rd && rsel == REG_STATUS_LOW) |=> o_rdata == $past(sel_stat);
  endproperty
  a_sel_read: assert property (p_sel_read) // see RULE1
    else $error("status read not from selected port");

  property p_len_set;
    i_line_len_chg[1] |=> stat_all[1][6];
  endproperty
  a_len_set: assert property (p_len_set) // see RULE2
    else $error("line length flag not set");

  property p_two_clear;
    (clr_two[2] && !i_line_len_chg[2] && !i_line_cnt_chg[2]
     && !i_buf_overflow[2]) |=> stat_all[2][6:4] == 3'h0;
  endproperty
  a_two_clear: assert property (p_two_clear) // see RULE3
    else $error("status two read did not clear");

  property p_ovf_set;
    i_buf_overflow[2] |=> stat_all[2][4];
  endproperty
  a_ovf_set: assert property (p_ovf_set) // see RULE4
    else $error("overflow flag not set");

  property p_par_set;
    i_parity_err[3] |=> stat_all[3][2];
  endproperty
  a_par_set: assert property (p_par_set) // see RULE5
    else $error("parity flag not set");

  property p_valid_keep;
    (stat_all[1][1] && !clr_one[1]) |=> stat_all[1][1];
  endproperty
  a_valid_keep: assert property (p_valid_keep) // see RULE6
    else $error("valid change flag lost");

  property p_one_clear;
    (clr_one[1] && !i_lock_chg[1] && !i_valid_chg[1] && !i_parity_err[1])
      |=> stat_all[1][2:0] == 3'h0;
  endproperty
  a_one_clear: assert property (p_one_clear) // see RULE7
    else $error("status one read did not clear");

  property p_gate;
    (stat_all[1][6] && ctrl_low_q[1][6]) |=> o_irq;
  endproperty
  a_gate: assert property (p_gate) // see RULE14
    else $error("enabled status gave no interrupt");

  property p_irq_low;
    (pend == 4'h0) [*2] |-> !o_irq;
  endproperty
  a_irq_low: assert property (p_irq_low) // see RULE15
    else $error("interrupt without pending status");

  property p_reserved;
    (i_rd && rsel == REG_STATUS_LOW) |=> !o_rdata[7] && !o_rdata[3];
  endproperty
  a_reserved: assert property (p_reserved) // see RULE16
    else $error("reserved status bit read nonzero");

  c_status_read: cover property (
    i_rd && rsel == REG_STATUS_LOW && sel_stat != 8'h00);
  c_irq_rise: cover property (!o_irq ##1 o_irq);
  c_sensor_clear: cover property (clr_sensor[0] && srise_all[0] != 8'h00);
endmodule // rx_port_interrupt_status

`default_nettype wire

// ===== hdl/rx_irq_regs.svh
`ifndef RX_IRQ_REGS_SVH
`define RX_IRQ_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RX_PORT_SELECT_ADDR 8'h4C
`define PORT_IRQ_CONTROL_LOW_ADDR 8'hD9
`define PORT_IRQ_STATUS_LOW_ADDR 8'hDB
`define FWD_GPIO_STATUS_ADDR 8'hDC
`define FWD_GPIO_IRQ_CONTROL_ADDR 8'hDD
`define SENSOR_RISE_IRQ_STATUS_ADDR 8'hDE
`define RX_PORT_STATUS_ONE_ADDR 8'hD0
`define RX_PORT_STATUS_TWO_ADDR 8'hD1

// ****************************************************************
// Field positions and masks
// ****************************************************************
`define LINE_LENGTH_CHANGE_BIT 6
`define LINE_COUNT_CHANGE_BIT 5
`define RX_BUFFER_OVERFLOW_BIT 4
`define LINK_PARITY_ERROR_BIT 2
`define PORT_VALID_CHANGE_BIT 1
`define LOCK_CHANGE_BIT 0
`define STATUS_LOW_VALID_MASK 8'h77
`define GPIO_FLAG_LSB 4

// ****************************************************************
// Reset values
// ****************************************************************
`define REG_RESET_VALUE 8'h00
`define PORT_SELECT_RESET 2'h0

`endif

// ===== hdl/rx_irq_pkg.sv
`default_nettype none

package rx_irq_pkg;
  `include "rx_irq_regs.svh"

  typedef logic [1:0] port_sel_t;
  typedef logic [7:0] reg_byte_t;

  // Which register an address points at
  typedef enum logic [3:0] {
    REG_NONE = 4'h0,
    REG_PORT_SELECT = 4'h1,
    REG_CONTROL_LOW = 4'h2,
    REG_STATUS_LOW = 4'h3,
    REG_GPIO_STATUS = 4'h4,
    REG_GPIO_CONTROL = 4'h5,
    REG_SENSOR_RISE = 4'h6,
    REG_PORT_STATUS_ONE = 4'h7,
    REG_PORT_STATUS_TWO = 4'h8
  } reg_id_t;

  // Address decode, shared by the read and the write path
  function automatic reg_id_t decode_addr(input logic [7:0] addr);
    case (addr)
      `RX_PORT_SELECT_ADDR: decode_addr = REG_PORT_SELECT;
      `PORT_IRQ_CONTROL_LOW_ADDR: decode_addr = REG_CONTROL_LOW;
      `PORT_IRQ_STATUS_LOW_ADDR: decode_addr = REG_STATUS_LOW;
      `FWD_GPIO_STATUS_ADDR: decode_addr = REG_GPIO_STATUS;
      `FWD_GPIO_IRQ_CONTROL_ADDR: decode_addr = REG_GPIO_CONTROL;
      `SENSOR_RISE_IRQ_STATUS_ADDR: decode_addr = REG_SENSOR_RISE;
      `RX_PORT_STATUS_ONE_ADDR: decode_addr = REG_PORT_STATUS_ONE;
      `RX_PORT_STATUS_TWO_ADDR: decode_addr = REG_PORT_STATUS_TWO;
      default: decode_addr = REG_NONE;
    endcase
  endfunction

  // Rising and falling edges between two samples
  function automatic reg_byte_t rise_of(input reg_byte_t cur,
                                        input reg_byte_t prev);
    rise_of = cur & ~prev;
  endfunction

  function automatic reg_byte_t fall_of(input reg_byte_t cur,
                                        input reg_byte_t prev);
    fall_of = ~cur & prev;
  endfunction
endpackage

`default_nettype wire

// ===== hdl/port_irq_unit.sv
`default_nettype none

module port_irq_unit
  import rx_irq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_line_len_chg,
  input wire logic i_line_cnt_chg,
  input wire logic i_buf_overflow,
  input wire logic i_parity_err,
  input wire logic i_valid_chg,
  input wire logic i_lock_chg,
  input wire logic [3:0] i_gpio_level,
  input wire logic [7:0] i_gpio_ctrl,
  input wire logic [7:0] i_sensor_status_bits,
  input wire logic [7:0] i_sensor_rise_mask,
  input wire logic i_clr_one,
  input wire logic i_clr_two,
  input wire logic i_clr_gpio,
  input wire logic i_clr_sensor,
  output logic [7:0] o_status_low,
  output logic [7:0] o_gpio_status,
  output logic [7:0] o_sensor_rise
);
  logic [7:0] stat_q, stat_d, sprev_q, sprev_d, srise_q, srise_d;
  logic [3:0] gflag_q, gflag_d, level_q, level_d;
  logic [3:0] rise_en, fall_en, gset;
  logic [7:0] grise, gfall, sset;

  // ****************************************************************
  // Edge detection and sticky flags
  // ****************************************************************
  // Set terms are OR-ed after the clear so an event on a read wins
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rise_en[i] = i_gpio_ctrl[2*i];
      fall_en[i] = i_gpio_ctrl[2*i+1];
    end
    grise = rise_of({4'h0, i_gpio_level}, {4'h0, level_q});
    gfall = fall_of({4'h0, i_gpio_level}, {4'h0, level_q});
    gset = (grise[3:0] & rise_en) | (gfall[3:0] & fall_en); // see RULE10
    sset = rise_of(i_sensor_status_bits, sprev_q) & i_sensor_rise_mask;
    stat_d = stat_q;
    if (i_clr_one) begin
      stat_d[2:0] = 3'h0; // see RULE5
    end
    if (i_clr_two) begin
      stat_d[6:4] = 3'h0; // see RULE2
    end
    stat_d[`LINE_LENGTH_CHANGE_BIT] |= i_line_len_chg; // see RULE2
    stat_d[`LINE_COUNT_CHANGE_BIT] |= i_line_cnt_chg; // see RULE3
    stat_d[`RX_BUFFER_OVERFLOW_BIT] |= i_buf_overflow; // see RULE4
    stat_d[`LINK_PARITY_ERROR_BIT] |= i_parity_err; // see RULE5
    stat_d[`PORT_VALID_CHANGE_BIT] |= i_valid_chg; // see RULE6
    stat_d[`LOCK_CHANGE_BIT] |= i_lock_chg; // see RULE7
    stat_d = stat_d & `STATUS_LOW_VALID_MASK; // see RULE16
    gflag_d = (i_clr_gpio ? 4'h0 : gflag_q) | gset; // see RULE8
    level_d = i_gpio_level; // see RULE9
    sprev_d = i_sensor_status_bits;
    srise_d = (i_clr_sensor ? 8'h00 : srise_q) | sset; // see RULE12
  end

  // Level history starts low, so a pin high at reset counts as a rise
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_q <= `REG_RESET_VALUE;
      gflag_q <= 4'h0;
      level_q <= 4'h0;
      sprev_q <= `REG_RESET_VALUE;
      srise_q <= `REG_RESET_VALUE;
    end else begin
      stat_q <= stat_d;
      gflag_q <= gflag_d;
      level_q <= level_d;
      sprev_q <= sprev_d;
      srise_q <= srise_d;
    end
  end

  assign o_status_low = stat_q;
  assign o_gpio_status = {gflag_q, level_q};
  assign o_sensor_rise = srise_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_gpio_level;
    !i_rst |=> o_gpio_status[3:0] == $past(i_gpio_level);
  endproperty
  a_gpio_level: assert property (p_gpio_level) // see RULE9
    else $error("gpio level not reported");

  property p_gpio_rise;
    (i_gpio_level[3] && !level_q[3] && i_gpio_ctrl[6])
      |=> o_gpio_status[7];
  endproperty
  a_gpio_rise: assert property (p_gpio_rise) // see RULE11
    else $error("gpio3 rise not flagged");

  property p_gpio_fall;
    (!i_gpio_level[0] && level_q[0] && i_gpio_ctrl[1])
      |=> o_gpio_status[`GPIO_FLAG_LSB];
  endproperty
  a_gpio_fall: assert property (p_gpio_fall) // see RULE10
    else $error("gpio0 fall not flagged");

  property p_gpio_clear;
    (i_clr_gpio && gset == 4'h0) |=> o_gpio_status[7:4] == 4'h0;
  endproperty
  a_gpio_clear: assert property (p_gpio_clear) // see RULE8
    else $error("gpio flags not cleared on read");

  property p_sensor_rise;
    (i_sensor_status_bits[0] && !sprev_q[0] && i_sensor_rise_mask[0])
      |=> o_sensor_rise[0];
  endproperty
  a_sensor_rise: assert property (p_sensor_rise) // see RULE12
    else $error("sensor rise not latched");

  property p_sensor_clear;
    (i_clr_sensor && sset == 8'h00) |=> o_sensor_rise == 8'h00;
  endproperty
  a_sensor_clear: assert property (p_sensor_clear) // see RULE13
    else $error("sensor rise not cleared on read");
endmodule // port_irq_unit

`default_nettype wire

// ===== testbench/reg_host.sv
`default_nettype none

module reg_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_rd
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Idle bus
  // ****************************************************************
  // Quiet lines at time zero, strobes low
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
  end

  // ****************************************************************
  // Register accesses
  // ****************************************************************
  // One-cycle write strobe; released lines show the inverse of their last
  // value so a stale byte can never pass for a fresh one
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk);
    o_addr <= addr;
    o_wdata <= data;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~addr;
    o_wdata <= ~data;
  endtask

  // One-cycle read strobe, answer awaited for a few cycles at most
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                          output logic ok);
    int n;
    @(posedge i_clk);
    o_addr <= addr;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~addr;
    ok = 1'b0;
    data = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (i_rvalid === 1'b1) begin
        ok = 1'b1;
        data = i_rdata;
      end else begin
        @(posedge i_clk);
      end
    end
  endtask
endmodule // reg_host

`default_nettype wire

// ===== testbench/test_rx_port_interrupt_status.sv
`default_nettype none
`include "rx_irq_regs.svh"

module test_rx_port_interrupt_status
  import rx_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic i_clk, i_rst, i_wr, i_rd, o_rvalid, o_irq;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic [3:0] i_line_len_chg, i_line_cnt_chg, i_buf_overflow;
  logic [3:0] i_parity_err, i_valid_chg, i_lock_chg;
  logic [3:0][3:0] i_fwd_gpio_level;
  logic [3:0][7:0] i_sensor_status_bits, i_sensor_rise_mask;
  int n_fail, n_compared;

  rx_port_interrupt_status uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr),
    .i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_irq(o_irq), .i_line_len_chg(i_line_len_chg),
    .i_line_cnt_chg(i_line_cnt_chg), .i_buf_overflow(i_buf_overflow),
    .i_parity_err(i_parity_err), .i_valid_chg(i_valid_chg),
    .i_lock_chg(i_lock_chg), .i_fwd_gpio_level(i_fwd_gpio_level),
    .i_sensor_status_bits(i_sensor_status_bits),
    .i_sensor_rise_mask(i_sensor_rise_mask)
  );

  reg_host host (
    .i_clk(i_clk), .i_rdata(o_rdata), .i_rvalid(o_rvalid),
    .o_addr(i_addr), .o_wr(i_wr), .o_wdata(i_wdata), .o_rd(i_rd)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Interrupt is looked at one edge later, once its cause has landed
  task automatic check_irq(input logic exp);
    @(posedge i_clk);
    #1;
    check_byte({7'h00, o_irq}, {7'h00, exp});
  endtask

  // A missing answer is turned into a mismatch
  task automatic expect_read(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] data;
    logic ok;
    host.read_reg(addr, data, ok);
    if (ok !== 1'b1) data = ~exp;
    check_byte(data, exp);
  endtask

  // One-cycle event pulses, kinds laid out as the status low bits
  task automatic fire(input logic [7:0] kinds, input int p);
    @(posedge i_clk);
    i_line_len_chg[p] <= kinds[6];
    i_line_cnt_chg[p] <= kinds[5];
    i_buf_overflow[p] <= kinds[4];
    i_parity_err[p] <= kinds[2];
    i_valid_chg[p] <= kinds[1];
    i_lock_chg[p] <= kinds[0];
    @(posedge i_clk);
    {i_line_len_chg, i_line_cnt_chg, i_buf_overflow} <= 12'h000;
    {i_parity_err, i_valid_chg, i_lock_chg} <= 12'h000;
  endtask

  // Edge detection needs a history cycle, so levels get time to settle
  task automatic settle();
    repeat (3) @(posedge i_clk);
  endtask

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Clock, reset, watchdog
  // ****************************************************************
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // About 120 cycles of traffic; the limit leaves a wide margin
  initial begin
    #(5000 * 8);
    n_fail++;
    conclude();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    n_fail = 0;
    n_compared = 0;
    i_rst = 1'b1;
    {i_line_len_chg, i_line_cnt_chg, i_buf_overflow} = 12'h000;
    {i_parity_err, i_valid_chg, i_lock_chg} = 12'h000;
    i_fwd_gpio_level = 16'h0000;
    i_sensor_status_bits = 32'h00000000;
    i_sensor_rise_mask = 32'h00000000;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;

    // Reset values, write-only and unmapped places read zero
    expect_read(`PORT_IRQ_STATUS_LOW_ADDR, 8'h00);
    expect_read(`FWD_GPIO_STATUS_ADDR, 8'h00);
    expect_read(`FWD_GPIO_IRQ_CONTROL_ADDR, 8'h00);
    expect_read(`SENSOR_RISE_IRQ_STATUS_ADDR, 8'h00);
    expect_read(`RX_PORT_SELECT_ADDR, 8'h00);
    expect_read(8'h10, 8'h00);
    check_irq(1'b0);
    $display("test reset done");

    // Port select and the two clearing groups
    host.write_reg(`RX_PORT_SELECT_ADDR, 8'h02);
    fire(8'h77, 2);
    expect_read(`PORT_IRQ_STATUS_LOW_ADDR, 8'h77);
    host.write_reg(`RX_PORT_SELECT_ADDR, 8'h00);
    expect_read(`PORT_IRQ_STATUS_LOW_ADDR, 8'h00);
    host.write_reg(`RX_PORT_SELECT_ADDR, 8'hFE);
    expect_read(`RX_PORT_SELECT_ADDR, 8'h02);
    expect_read(`RX_PORT_STATUS_ONE_ADDR, 8'h00);
    expect_read(`PORT_IRQ_STATUS_LOW_ADDR, 8'h70);
    expect_read(`RX_PORT_STATUS_TWO_ADDR, 8'h00);
    expect_read(`PORT_IRQ_STATUS_LOW_ADDR, 8'h00);
    host.write_reg(`PORT_IRQ_STATUS_LOW_ADDR, 8'hFF);
    expect_read(`PORT_IRQ_STATUS_LOW_ADDR, 8'h00);
    fire(8'h10, 2);
    fire(8'h01, 2);
    expect_read(`PORT_IRQ_STATUS_LOW_ADDR, 8'h11);
    expect_read(`RX_PORT_STATUS_ONE_ADDR, 8'h00);
    expect_read(`PORT_IRQ_STATUS_LOW_ADDR, 8'h10);
    $display("test port select done");

    // Enables gate the interrupt per port, unenabled port 3 stays quiet
    host.write_reg(`RX_PORT_SELECT_ADDR, 8'h01);
    fire(8'h40, 1);
    check_irq(1'b0);
    host.write_reg(`PORT_IRQ_CONTROL_LOW_ADDR, 8'hFF);
    check_irq(1'b1);
    expect_read(`PORT_IRQ_CONTROL_LOW_ADDR, 8'h77);
    expect_read(`RX_PORT_STATUS_TWO_ADDR, 8'h00);
    check_irq(1'b0);
    fire(8'h04, 3);
    check_irq(1'b0);
    fire(8'h02, 1);
    check_irq(1'b1);
    expect_read(`RX_PORT_STATUS_ONE_ADDR, 8'h00);
    check_irq(1'b0);
    $display("test interrupt gating done");

    // GPIO levels, enabled edges and read clear on port 3
    host.write_reg(`RX_PORT_SELECT_ADDR, 8'h03);
    host.write_reg(`FWD_GPIO_IRQ_CONTROL_ADDR, 8'h42);
    @(posedge i_clk);
    i_fwd_gpio_level[3] <= 4'h9;
    settle();
    check_irq(1'b1);
    expect_read(`FWD_GPIO_STATUS_ADDR, 8'h89);
    expect_read(`FWD_GPIO_STATUS_ADDR, 8'h09);
    @(posedge i_clk);
    i_fwd_gpio_level[3] <= 4'h0;
    settle();
    expect_read(`FWD_GPIO_STATUS_ADDR, 8'h10);
    expect_read(`FWD_GPIO_STATUS_ADDR, 8'h00);
    expect_read(`FWD_GPIO_IRQ_CONTROL_ADDR, 8'h00);
    $display("test gpio done");

    // Masked sensor rising edges on port 0
    host.write_reg(`RX_PORT_SELECT_ADDR, 8'h00);
    @(posedge i_clk);
    i_sensor_rise_mask[0] <= 8'h0F;
    i_sensor_status_bits[0] <= 8'hF0;
    settle();
    expect_read(`SENSOR_RISE_IRQ_STATUS_ADDR, 8'h00);
    @(posedge i_clk);
    i_sensor_status_bits[0] <= 8'hFF;
    settle();
    check_irq(1'b1);
    expect_read(`SENSOR_RISE_IRQ_STATUS_ADDR, 8'h0F);
    expect_read(`SENSOR_RISE_IRQ_STATUS_ADDR, 8'h00);
    check_irq(1'b0);
    $display("test sensor done");
    conclude();
  end
endmodule // test_rx_port_interrupt_status

`default_nettype wire
